// File: core/scfe_front_end.sv
// Serial command front end with lock indicator
`default_nettype none
// Function
// RULE1: Host ends each command with CR; CR triggers execution of collected text.
// RULE2: Line feeds and spaces are dropped before the command is interpreted.
// RULE3: Command names match regardless of letter case.
// RULE4: Reply characters are followed by CR then LF; no reply means nothing sent.
// RULE5: Error sends partial reply, question mark, 8-bit code, then CR LF. The code sends no partial reply, only question mark, code, CR LF.
// RULE6: Lock output high while unlocked, low once locked.
// RULE7: Reference runs at once; lock indicated within about 120 seconds.
// RULE8: Telemetry dump returns fifteen 4-digit hex words then CR LF.
// RULE9: Error code is two hex digits, high nibble first.
module scfe_front_end
  import scfe_pkg::*;
#(
  parameter longint unsigned LOCK_CYCLES = scfe_pkg::SCFE_LOCK_CYCLES,
  parameter int unsigned BUF_DEPTH = scfe_pkg::SCFE_BUF_DEPTH
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic [scfe_pkg::SCFE_TELEM_WORDS*scfe_pkg::SCFE_TELEM_W-1:0] telem,
  input wire logic osc_locked,
  input wire logic tx_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic lock_b,
  output logic busy
);
  import scfe_pkg::*;

  function automatic logic [7:0] hex_char(input logic [3:0] n);
    hex_char = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction

  function automatic logic [7:0] to_upper(input logic [7:0] c);
    to_upper = (c >= 8'h61 && c <= 8'h7A) ? (c - 8'h20) : c;
  endfunction

  logic [7:0] cmd_buf [BUF_DEPTH];
  logic [4:0] cmd_len;
  logic overflow;
  scfe_state_e state;
  logic [7:0] err_code;
  logic [3:0] word_idx;
  logic [1:0] nib_idx;
  logic [63:0] lock_cnt;
  logic locked_seen;

  // Bytes that come during a reply are dropped, not queued
  wire rx_drop = (rx_data == SCFE_LF) || (rx_data == SCFE_SP);
  wire rx_cr = rx_valid && (rx_data == SCFE_CR);
  wire rx_store = rx_valid && !rx_drop && !rx_cr && (state == SCFE_IDLE);
  wire tx_adv = !tx_valid || tx_ready;

  logic name_match;
  always_comb begin
    name_match = (cmd_len == 5'(SCFE_CMD_LEN)) && !overflow;
    for (int i = 0; i < SCFE_CMD_LEN; i++) begin
      if (to_upper(cmd_buf[i]) != SCFE_TELEM_NAME[8*(SCFE_CMD_LEN-1-i) +: 8]) begin
        name_match = 1'b0;
      end
    end
  end

  wire exec = rx_cr && (state == SCFE_IDLE);
  wire empty_cmd = (cmd_len == 5'h00) && !overflow;
  wire [15:0] cur_word = telem[16*(SCFE_TELEM_WORDS-1-int'(word_idx)) +: 16];
  wire [3:0] cur_nib = cur_word[4*(3-int'(nib_idx)) +: 4];
  wire last_nib = (nib_idx == 2'h3) && (word_idx == 4'(SCFE_TELEM_WORDS-1));

  // Raw bytes kept; case folding happens at compare time
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_len <= 5'h00;
      overflow <= 1'b0;
    end else if (exec) begin
      cmd_len <= 5'h00; // see RULE1
      overflow <= 1'b0;
    end else if (rx_store) begin // see RULE2
      if (cmd_len < 5'(BUF_DEPTH)) begin
        cmd_buf[cmd_len[3:0]] <= rx_data;
        cmd_len <= cmd_len + 5'h01;
      end else begin
        overflow <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= SCFE_IDLE;
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      err_code <= 8'h00;
      word_idx <= 4'h0;
      nib_idx <= 2'h0;
    end else if (tx_adv || state == SCFE_IDLE) begin
      // A CR may come while the last LF still waits, so idle decodes regardless of the sink
      if (tx_adv) begin
        tx_valid <= 1'b0;
      end
      case (state)
        SCFE_IDLE: begin
          if (exec && !empty_cmd) begin
            if (name_match) begin // see RULE3
              state <= SCFE_HEX;
              word_idx <= 4'h0;
              nib_idx <= 2'h0;
            end else begin
              state <= SCFE_QMARK;
              err_code <= overflow ? SCFE_ERR_OVERFLOW : SCFE_ERR_UNKNOWN;
            end
          end
        end
        SCFE_HEX: begin
          tx_valid <= 1'b1;
          tx_data <= hex_char(cur_nib); // see RULE8
          nib_idx <= nib_idx + 2'h1;
          if (nib_idx == 2'h3) begin
            word_idx <= word_idx + 4'h1;
          end
          if (last_nib) begin
            state <= SCFE_TX_CR;
          end
        end
        SCFE_QMARK: begin
          tx_valid <= 1'b1;
          tx_data <= SCFE_QM; // see RULE5
          state <= SCFE_ERRHI;
        end
        SCFE_ERRHI: begin
          tx_valid <= 1'b1;
          tx_data <= hex_char(err_code[7:4]); // see RULE9
          state <= SCFE_ERRLO;
        end
        SCFE_ERRLO: begin
          tx_valid <= 1'b1;
          tx_data <= hex_char(err_code[3:0]); // see RULE9
          state <= SCFE_TX_CR;
        end
        SCFE_TX_CR: begin
          tx_valid <= 1'b1;
          tx_data <= SCFE_CR; // see RULE4
          state <= SCFE_TX_LF;
        end
        SCFE_TX_LF: begin
          tx_valid <= 1'b1;
          tx_data <= SCFE_LF; // see RULE4
          state <= SCFE_IDLE;
        end
        default: state <= SCFE_IDLE;
      endcase
    end
  end

  // Lock shown only once the loop reports lock; the counter only times the wait for the lock coverage point
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lock_b <= 1'b1;
      lock_cnt <= 64'h0;
      locked_seen <= 1'b0;
    end else begin
      lock_b <= !osc_locked; // see RULE6
      if (lock_cnt < LOCK_CYCLES) begin
        lock_cnt <= lock_cnt + 64'h1; // see RULE7
      end
      locked_seen <= locked_seen || osc_locked;
    end
  end

  // Busy drops with the LF possibly still offered; idle accepts the next command anyway
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy <= 1'b0;
    end else begin
      busy <= (state != SCFE_IDLE);
    end
  end

  a_lock_follow: assert property (@(posedge clk) disable iff (!rst_b) // see RULE6
    ##1 (lock_b == !$past(osc_locked))) else $error("lock output does not follow lock state");
  a_lf_after_cr: assert property (@(posedge clk) disable iff (!rst_b) // see RULE4
    (tx_valid && tx_ready && tx_data == SCFE_CR && state == SCFE_TX_LF) |=> ##[0:1000] (tx_valid && tx_data == SCFE_LF))
    else $error("CR not followed by LF");
  a_err_qmark: assert property (@(posedge clk) disable iff (!rst_b) // see RULE5
    (state == SCFE_QMARK && tx_adv) |=> (tx_valid && tx_data == SCFE_QM)) else $error("no question mark on error");
  a_err_digit: assert property (@(posedge clk) disable iff (!rst_b) // see RULE9
    (state == SCFE_ERRHI && tx_adv) |=> (tx_data == hex_char($past(err_code[7:4])))) else $error("bad high digit");
  a_hold_data: assert property (@(posedge clk) disable iff (!rst_b) // see RULE4
    (tx_valid && !tx_ready) |=> (tx_valid && $stable(tx_data))) else $error("tx data changed while stalled");
  a_drop_space: assert property (@(posedge clk) disable iff (!rst_b) // see RULE2
    (rx_valid && rx_drop) |=> $stable(cmd_len)) else $error("space or LF stored");
  a_cr_clears: assert property (@(posedge clk) disable iff (!rst_b) // see RULE1
    exec |=> (cmd_len == 5'h00)) else $error("buffer not cleared on CR");
  a_telem_start: assert property (@(posedge clk) disable iff (!rst_b) // see RULE3
    (exec && name_match && tx_adv) |=> (state == SCFE_HEX)) else $error("matched command not run");
  // Lock indicator
  a_lock_seen: assert property (@(posedge clk) disable iff (!rst_b) // see RULE6
    !lock_b |-> locked_seen) else $error("lock shown without lock seen");
  // Reply framing
  a_telem_digit: assert property (@(posedge clk) disable iff (!rst_b) // see RULE8
    (state == SCFE_HEX && tx_adv) |=> (tx_valid && tx_data == hex_char($past(cur_nib)))) else $error("bad telemetry digit");
  a_word_step: assert property (@(posedge clk) disable iff (!rst_b) // see RULE8
    (state == SCFE_HEX && tx_adv && nib_idx == 2'h3 && !last_nib) |=> (state == SCFE_HEX && nib_idx == 2'h0))
    else $error("telemetry word step wrong");
  a_telem_end: assert property (@(posedge clk) disable iff (!rst_b) // see RULE8
    (state == SCFE_HEX && tx_adv && last_nib) |=> (state == SCFE_TX_CR)) else $error("telemetry not closed by CR");
  a_err_start: assert property (@(posedge clk) disable iff (!rst_b) // see RULE5
    (state == SCFE_QMARK && tx_adv) |=> (state == SCFE_ERRHI)) else $error("error code does not follow mark");
  a_err_low: assert property (@(posedge clk) disable iff (!rst_b) // see RULE9
    (state == SCFE_ERRLO && tx_adv) |=> (tx_data == hex_char($past(err_code[3:0])))) else $error("bad low digit");
  a_err_cr: assert property (@(posedge clk) disable iff (!rst_b) // see RULE5
    (state == SCFE_ERRLO && tx_adv) |=> (state == SCFE_TX_CR)) else $error("error code not closed by CR");
  a_overflow_code: assert property (@(posedge clk) disable iff (!rst_b) // see RULE5
    (exec && overflow) |=> (state == SCFE_QMARK && err_code == SCFE_ERR_OVERFLOW)) else $error("overflow not reported");
  a_no_reply: assert property (@(posedge clk) disable iff (!rst_b) // see RULE4
    (exec && empty_cmd && !tx_valid) |=> (!tx_valid && state == SCFE_IDLE)) else $error("empty command answered");
  c_telem: cover property (@(posedge clk) disable iff (!rst_b) state == SCFE_HEX && last_nib && tx_adv);
  c_error: cover property (@(posedge clk) disable iff (!rst_b) state == SCFE_ERRLO);
  c_lock: cover property (@(posedge clk) disable iff (!rst_b) $fell(lock_b));
  c_lock_in_time: cover property (@(posedge clk) disable iff (!rst_b) $fell(lock_b) && lock_cnt < LOCK_CYCLES);
  c_stall: cover property (@(posedge clk) disable iff (!rst_b) tx_valid && !tx_ready);
endmodule
`default_nettype wire

// File: core/scfe_pkg.sv
// Constants and types of the serial command front end
`default_nettype none
package scfe_pkg;
  localparam int unsigned SCFE_CLK_HZ = 40_000_000;
  localparam int unsigned SCFE_LOCK_TIME_S = 120;
  localparam longint unsigned SCFE_LOCK_CYCLES = longint'(SCFE_LOCK_TIME_S) * longint'(SCFE_CLK_HZ);
  localparam logic [7:0] SCFE_CR = 8'h0D;
  localparam logic [7:0] SCFE_LF = 8'h0A;
  localparam logic [7:0] SCFE_SP = 8'h20;
  localparam logic [7:0] SCFE_QM = 8'h3F;
  localparam int unsigned SCFE_BUF_DEPTH = 16;
  localparam int unsigned SCFE_TELEM_WORDS = 15;
  localparam int unsigned SCFE_TELEM_W = 16;
  localparam int unsigned SCFE_CMD_LEN = 8;
  // Command name in upper case, first character in the top byte
  localparam logic [63:0] SCFE_TELEM_NAME = 64'h4D4F4E49544F5231;
  localparam logic [7:0] SCFE_ERR_UNKNOWN = 8'h01;
  localparam logic [7:0] SCFE_ERR_OVERFLOW = 8'h02;
  typedef enum logic [2:0] {SCFE_IDLE, SCFE_HEX, SCFE_QMARK, SCFE_ERRHI, SCFE_ERRLO, SCFE_TX_CR, SCFE_TX_LF}
    scfe_state_e;
endpackage
`default_nettype wire

// File: tb/scfe_front_end_tb.sv
// Testbench for the serial command front end
`default_nettype none
module scfe_front_end_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import scfe_pkg::*;
  logic clk, rst_b, rx_valid, osc_locked, slow, tx_ready, tx_valid, lock_b, busy;
  logic [7:0] rx_data, tx_data;
  logic [SCFE_TELEM_WORDS*SCFE_TELEM_W-1:0] telem;
  logic [7:0] q[$];
  int n_errors, checked;
  scfe_front_end #(.LOCK_CYCLES(100)) scfe_front_end_inst (.clk(clk), .rst_b(rst_b), .rx_valid(rx_valid),
    .rx_data(rx_data), .telem(telem), .osc_locked(osc_locked), .tx_ready(tx_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .lock_b(lock_b), .busy(busy));
  scfe_host_model scfe_host_model_inst (.clk(clk), .rst_b(rst_b), .slow(slow), .tx_ready(tx_ready));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) if (tx_valid && tx_ready) q.push_back(tx_data);
  task test_done;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      $display("BAD %0t %h %h", $time, g, e);
      n_errors++;
    end
  endtask
  function automatic logic [7:0] hx(input logic [3:0] n);
    return n < 4'hA ? 8'h30 + n : 8'h37 + n;
  endfunction
  task put(input logic [7:0] b);
    rx_data <= b;
    rx_valid <= 1'b1;
    @(posedge clk);
    rx_valid <= 1'b0;
    @(posedge clk);
  endtask
  // Sends a command, then compares the whole reply; CR LF is added when a reply is expected
  task run(input string c, input string e);
    int k;
    q.delete();
    foreach (c[i]) put(c[i]);
    put(SCFE_CR);
    @(posedge clk);
    chk({7'h00, busy}, (e.len() > 0) ? 8'h01 : 8'h00);
    if (e.len() > 0) e = {e, string'(SCFE_CR), string'(SCFE_LF)};
    for (k = 0; k < 3000 && (q.size() < e.len() || busy !== 1'b0); k++) @(posedge clk);
    if (k == 3000) begin
      n_errors++;
      test_done();
    end
    repeat (6) @(posedge clk);
    chk(8'(q.size()), 8'(e.len()));
    foreach (e[i]) chk(q[i], e[i]);
  endtask
  task t_lock;
    chk({7'h00, lock_b}, 8'h01);
    osc_locked <= 1'b1;
    repeat (3) @(posedge clk);
    chk({7'h00, lock_b}, 8'h00);
    osc_locked <= 1'b0;
    repeat (3) @(posedge clk);
    chk({7'h00, lock_b}, 8'h01);
    $display("lock test done");
  endtask
  task t_telem;
    string e;
    e = "";
    slow <= 1'b1;
    for (int i = 0; i < 15; i++)
      for (int j = 0; j < 4; j++) e = {e, string'(hx(telem[239-16*i-4*j -: 4]))};
    run("mOn iTor\n1", e);
    slow <= 1'b0;
    $display("telemetry test done");
  endtask
  task t_err;
    run("xy", "?01");
    run("abcdefghijklmnopq", "?02");
    $display("error test done");
  endtask
  task t_empty;
    run(" \n", "");
    $display("empty test done");
  endtask
  initial begin
    rst_b = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    osc_locked = 1'b0;
    slow = 1'b0;
    n_errors = 0;
    checked = 0;
    for (int i = 0; i < 15; i++) telem[239-16*i -: 16] = 16'hA5C3 ^ 16'(16'h1111 * i);
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_lock();
    t_telem();
    t_err();
    t_empty();
    test_done();
  end
endmodule
`default_nettype wire

// File: tb/scfe_host_model.sv
// Terminal side model: byte sink with optional stalls
`default_nettype none
module scfe_host_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic slow,
  output logic tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) cnt <= 2'h0;
    else cnt <= cnt + 2'h1;
  end
  // Slow mode takes one byte in four, so each byte must stand while refused
  assign tx_ready = !slow || cnt == 2'h3;
endmodule
`default_nettype wire
